// >>> rtl/keypad_dev.sv
// keypad device: pin configuration registers, debounce, interrupt status, link slave
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/100ps
module keypad_dev
  import keypad_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int SCAN_CYCLES     = SCAN_CYC
) (
  input  wire logic             core_clk_in,           // 125 MHz clock
  input  wire logic             resetn_in,             // async reset, active low
  keypad_link_if.dev            link,                  // serial link to host
  input  wire logic [PIN_N-1:0] pins_in,               // pin levels
  input  wire logic             pin_reset_n_in,        // reset pin, active low
  input  wire logic [PIN_N-1:0] kp_sel_in,             // 1 = pin in keypad array
  input  wire logic [PIN_N-1:0] irq_en_in,             // per-pin gpi interrupt enable
  input  wire logic [PIN_N-1:0] data_out_in,           // levels for output pins
  input  wire logic             key_event_in,          // scan engine queued an event
  input  wire logic             lock_start_in,         // lock sequence started
  input  wire logic             salute_in,             // three key combination seen
  input  wire logic             overrun_event_in,      // event buffer overflowed
  input  wire logic             overrun_wrap_mode_in,  // overflow wrap mode
  input  wire logic             overrun_irq_enable_in, // overflow interrupt enable
  output logic      [PIN_N-1:0] pin_drive_out,         // pin output level
  output logic      [PIN_N-1:0] pin_oe_n_out,          // low while pin driven
  output logic      [PIN_N-1:0] pullup_en_out,         // pull-up enable
  output logic      [PIN_N-1:0] input_state_out,       // debounced pin state
  output logic      [COL_N-1:0] key_accept_out,        // accepted column presses
  output logic      [ST_W-1:0]  status_out,            // interrupt status flags
  output logic                  soft_reset_out         // debounced reset pin active
);
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [SCAN_W-1:0] SCAN_LAST = SCAN_W'(SCAN_CYCLES - 1);
  localparam int L_SCLK = 0;
  localparam int L_SEL = 1;
  localparam int L_MOSI = 2;

  typedef struct packed {
    logic [PIN_N-1:0]            dir;
    logic [PIN_N-1:0]            pol;
    logic [PIN_N-1:0]            dbo;
    logic [PIN_N-1:0]            puo;
    logic [ST_W-1:0]             sts;
    logic [PIN_N-1:0]            ps1;
    logic [PIN_N-1:0]            ps2;
    logic [PIN_N-1:0]            ps3;
    logic [PIN_N-1:0]            stab;
    logic [PIN_N-1:0][DB_W-1:0]  cnt;
    logic [2:0]                  rs;
    logic                        rstab;
    logic [DB_W-1:0]             rcnt;
    logic [SCAN_W-1:0]           scan_cnt;
    logic [COL_N-1:0]            scan_prev;
    logic [COL_N-1:0]            keys;
    logic [2:0]                  l1;
    logic [2:0]                  l2;
    logic [2:0]                  l3;
    logic [2:0]                  lf;
    logic [4:0]                  bitc;
    logic [FRAME_BITS-1:0]       sh;
    logic [7:0]                  tx;
    logic                        miso;
    logic [PIN_N-1:0]            pout;
    logic [PIN_N-1:0]            poe_n;
    logic [PIN_N-1:0]            pu_en;
  } dev_state_t;

  dev_state_t r_r;
  dev_state_t r_nxt;

  function automatic logic [PIN_N-1:0] wr3(input logic [PIN_N-1:0] v, input logic [6:0] a,
                                          input logic [7:0] d, input logic [6:0] o0,
                                          input logic [6:0] o1, input logic [6:0] o2);
    wr3 = v;
    if (a == o0) wr3[7:0] = d;
    if (a == o1) wr3[15:8] = d;
    if (a == o2) wr3[17:16] = d[1:0];
  endfunction

  function automatic logic [7:0] rd3(input logic [PIN_N-1:0] v, input logic [6:0] a,
                                     input logic [6:0] o0, input logic [6:0] o1, input logic [6:0] o2);
    rd3 = 8'h00;
    if (a == o0) rd3 = v[7:0];
    if (a == o1) rd3 = v[15:8];
    if (a == o2) rd3 = {6'h00, v[17:16]};
  endfunction

  function automatic logic [7:0] read_reg(input dev_state_t s, input logic [6:0] a);
    read_reg = rd3(s.dir, a, OFS_DIR_ROWS, OFS_DIR_COLS_LO, OFS_DIR_COLS_HI)
             | rd3(s.pol, a, OFS_POL_ROWS, OFS_POL_COLS_LO, OFS_POL_COLS_HI)
             | rd3(s.dbo, a, OFS_DBO_ROWS, OFS_DBO_COLS_LO, OFS_DBO_COLS_HI)
             | rd3(s.puo, a, OFS_PUO_ROWS, OFS_PUO_COLS_LO, OFS_PUO_COLS_HI);
    if (a == OFS_INT_STATUS) read_reg = {3'h0, s.sts};
  endfunction

  always_comb begin
    logic [PIN_N-1:0]      gpi;
    logic [PIN_N-1:0]      hit;
    logic [COL_N-1:0]      seen;
    logic [ST_W-1:0]       set;
    logic [ST_W-1:0]       clr;
    logic [2:0]            lf_n;
    logic [FRAME_BITS-1:0] sh_n;
    gpi = '0;
    hit = '0;
    seen = '0;
    set = '0;
    clr = '0;
    lf_n = '0;
    sh_n = '0;
    r_nxt = r_r;
    r_nxt.ps1 = pins_in;
    r_nxt.ps2 = r_r.ps1;
    r_nxt.ps3 = r_r.ps2;
    for (int i = 0; i < PIN_N; i++) begin
      // a change counts only once the last two sync stages agree
      if (r_r.ps2[i] != r_r.ps3[i]) begin
        r_nxt.cnt[i] = r_r.cnt[i];
      end else if (r_r.dbo[i]) begin
        r_nxt.stab[i] = r_r.ps3[i];
        r_nxt.cnt[i] = '0;
      end else if (r_r.ps3[i] == r_r.stab[i]) begin
        r_nxt.cnt[i] = '0;
      end else if (r_r.cnt[i] == DB_LAST) begin
        r_nxt.stab[i] = r_r.ps3[i];
        r_nxt.cnt[i] = '0;
      end else begin
        r_nxt.cnt[i] = r_r.cnt[i] + 1'b1;
      end
    end
    // reset pin ignores debounce-off settings
    r_nxt.rs = {r_r.rs[1:0], pin_reset_n_in};
    if (r_r.rs[1] != r_r.rs[2] || r_r.rs[2] == r_r.rstab) begin
      r_nxt.rcnt = '0;
    end else if (r_r.rcnt == DB_LAST) begin
      r_nxt.rstab = r_r.rs[2];
      r_nxt.rcnt = '0;
    end else begin
      r_nxt.rcnt = r_r.rcnt + 1'b1;
    end
    // only a real change of the debounced level can fire, so defaults stay quiet
    gpi = ~kp_sel_in & ~r_r.dir & irq_en_in;
    for (int i = 0; i < PIN_N; i++) begin
      hit[i] = r_r.pol[i] ? (r_nxt.stab[i] & ~r_r.stab[i]) : (~r_nxt.stab[i] & r_r.stab[i]);
    end
    // column keys need the same press on two scans in a row
    if (r_r.scan_cnt == SCAN_LAST) begin
      r_nxt.scan_cnt = '0;
      seen = kp_sel_in[PIN_N-1:COL_BASE] & ~r_r.ps3[PIN_N-1:COL_BASE];
      r_nxt.scan_prev = seen;
      r_nxt.keys = seen & r_r.scan_prev;
    end else begin
      r_nxt.scan_cnt = r_r.scan_cnt + 1'b1;
    end
    set[ST_KEY] = key_event_in | (|(r_nxt.keys & ~r_r.keys));
    set[ST_GPI] = |(gpi & hit);
    set[ST_LOCK] = lock_start_in;
    set[ST_OVR] = overrun_event_in & overrun_wrap_mode_in & overrun_irq_enable_in;
    set[ST_SALUTE] = salute_in;
    // link slave: three-stage sync, level taken when stages two and three agree
    r_nxt.l1 = {link.mosi, link.sel_n, link.sclk};
    r_nxt.l2 = r_r.l1;
    r_nxt.l3 = r_r.l2;
    for (int k = 0; k < 3; k++) begin
      lf_n[k] = (r_r.l2[k] == r_r.l3[k]) ? r_r.l3[k] : r_r.lf[k];
    end
    r_nxt.lf = lf_n;
    if (lf_n[L_SEL]) begin
      r_nxt.bitc = '0;
    end else if (lf_n[L_SCLK] && !r_r.lf[L_SCLK]) begin
      sh_n = {r_r.sh[FRAME_BITS-2:0], lf_n[L_MOSI]};
      r_nxt.sh = sh_n;
      r_nxt.bitc = r_r.bitc + 1'b1;
      if (r_r.bitc == 5'(HDR_BITS - 1)) begin
        r_nxt.tx = read_reg(r_r, sh_n[6:0]);
      end
      if (r_r.bitc == 5'(FRAME_BITS - 1) && sh_n[FRAME_WRITE_BIT]) begin
        r_nxt.dir = wr3(r_r.dir, sh_n[14:8], sh_n[7:0], OFS_DIR_ROWS, OFS_DIR_COLS_LO, OFS_DIR_COLS_HI);
        r_nxt.pol = wr3(r_r.pol, sh_n[14:8], sh_n[7:0], OFS_POL_ROWS, OFS_POL_COLS_LO, OFS_POL_COLS_HI);
        r_nxt.dbo = wr3(r_r.dbo, sh_n[14:8], sh_n[7:0], OFS_DBO_ROWS, OFS_DBO_COLS_LO, OFS_DBO_COLS_HI);
        r_nxt.puo = wr3(r_r.puo, sh_n[14:8], sh_n[7:0], OFS_PUO_ROWS, OFS_PUO_COLS_LO, OFS_PUO_COLS_HI);
        if (sh_n[14:8] == OFS_INT_STATUS) clr = sh_n[ST_W-1:0];
      end
    end else if (!lf_n[L_SCLK] && r_r.lf[L_SCLK]) begin
      r_nxt.miso = r_r.tx[7];
      r_nxt.tx = {r_r.tx[6:0], 1'b0};
    end
    // a flag raised in the clearing cycle survives
    r_nxt.sts = (r_r.sts & ~clr) | set;
    if (!r_r.rstab) begin
      r_nxt.dir = RST_DIR;
      r_nxt.pol = RST_POL;
      r_nxt.dbo = RST_DBO;
      r_nxt.puo = RST_PUO;
      r_nxt.sts = RST_STATUS;
    end
    r_nxt.pout = data_out_in;
    r_nxt.poe_n = ~r_nxt.dir;
    r_nxt.pu_en = ~r_nxt.puo;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_r <= '0;
      r_r.stab <= RST_INPUT_STATE;
      r_r.ps1 <= RST_INPUT_STATE;
      r_r.ps2 <= RST_INPUT_STATE;
      r_r.ps3 <= RST_INPUT_STATE;
      r_r.rs <= 3'h7;
      r_r.rstab <= 1'b1;
      r_r.l1 <= 3'h2;
      r_r.l2 <= 3'h2;
      r_r.l3 <= 3'h2;
      r_r.lf <= 3'h2;
      r_r.poe_n <= '1;
      r_r.pu_en <= '1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign link.miso = r_r.miso;
  assign pin_drive_out = r_r.pout;
  assign pin_oe_n_out = r_r.poe_n;
  assign pullup_en_out = r_r.pu_en;
  assign input_state_out = r_r.stab;
  assign key_accept_out = r_r.keys;
  assign status_out = r_r.sts;
  assign soft_reset_out = ~r_r.rstab;
endmodule // keypad_dev

// >>> common/keypad_pkg.sv
// shared constants for the keypad gpio configuration slice and its link
// Operation
// - direction bit set drives pin, cleared is input
// - polarity picks falling/low or rising/high trigger
// - debounce-off bit bypasses input debouncing
// - debounce-off acts alike on gpi and rows
// - reset pin always debounced fifty microseconds
// - input change needs fifty microseconds stability
// - keypad debounce on columns, 25 ms scan
// - key accepted after two consecutive scans
// - pull-up-off bit cleared keeps pull-up enabled
// - salute flag bit 4, write one clears
// - overrun flag bit 3, write one clears
// - lock flag bit 2, write one clears
// - general input flag bit 1, write one clears
// - key event flag bit 0, write one clears
// - salute flag alone is not conclusive
// - enabled gpi change sets general input flag
// - debounced input state keeps default until change
// - overrun flag needs wrap mode and enable
package keypad_pkg;
  localparam int PIN_N = 18;
  localparam int COL_N = 10;
  localparam int COL_BASE = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_MHZ = 125;
  localparam int DEBOUNCE_US = 50;
  localparam int SCAN_MS = 25;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int SCAN_CYC = SCAN_MS * 1000 * CLK_MHZ;
  localparam int DB_W = 13;
  localparam int SCAN_W = 22;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam int FRAME_WRITE_BIT = 15;
  localparam int FRAME_ADDR_LSB = 8;
  localparam logic [6:0] OFS_INT_STATUS = 7'h02;
  localparam logic [6:0] OFS_DIR_ROWS = 7'h23;
  localparam logic [6:0] OFS_DIR_COLS_LO = 7'h24;
  localparam logic [6:0] OFS_DIR_COLS_HI = 7'h25;
  localparam logic [6:0] OFS_POL_ROWS = 7'h26;
  localparam logic [6:0] OFS_POL_COLS_LO = 7'h27;
  localparam logic [6:0] OFS_POL_COLS_HI = 7'h28;
  localparam logic [6:0] OFS_DBO_ROWS = 7'h29;
  localparam logic [6:0] OFS_DBO_COLS_LO = 7'h30;
  localparam logic [6:0] OFS_DBO_COLS_HI = 7'h2B;
  localparam logic [6:0] OFS_PUO_ROWS = 7'h2C;
  localparam logic [6:0] OFS_PUO_COLS_LO = 7'h3D;
  localparam logic [6:0] OFS_PUO_COLS_HI = 7'h2E;
  localparam int ST_KEY = 0;
  localparam int ST_GPI = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_OVR = 3;
  localparam int ST_SALUTE = 4;
  localparam int ST_W = 5;
  localparam logic [PIN_N-1:0] RST_DIR = 18'h00000;
  localparam logic [PIN_N-1:0] RST_POL = 18'h00000;
  localparam logic [PIN_N-1:0] RST_DBO = 18'h00000;
  localparam logic [PIN_N-1:0] RST_PUO = 18'h00000;
  localparam logic [PIN_N-1:0] RST_INPUT_STATE = 18'h3FFFF;
  localparam logic [ST_W-1:0] RST_STATUS = 5'h00;
  localparam logic HOST_OFS_CMD = 1'h0;
  localparam logic HOST_OFS_STATUS = 1'h1;
  localparam int HOST_BUSY_BIT = 0;
  localparam int HOST_DATA_LSB = 8;
endpackage

// >>> common/keypad_link_if.sv
// four-wire serial link between host controller and keypad device
`timescale 1ns/100ps
interface keypad_link_if;
  logic sclk;   // host-made link clock
  logic sel_n;  // frame select, low during a frame
  logic mosi;   // host to device data
  logic miso;   // device to host data
  modport dev (input sclk, input sel_n, input mosi, output miso);
  modport host (output sclk, output sel_n, output mosi, input miso);
endinterface

// >>> rtl/keypad_host.sv
// host controller: avalon-mm command registers driving the serial link to the keypad device
`timescale 1ns/100ps
module keypad_host
  import keypad_pkg::*;
(
  input  wire logic        core_clk_in,          // 125 MHz clock
  input  wire logic        resetn_in,            // async reset, active low
  keypad_link_if.host      link,                 // serial link to device
  input  wire logic        avs_address,          // word address
  input  wire logic        avs_read,             // read request
  input  wire logic        avs_write,            // write request
  input  wire logic [31:0] avs_writedata,        // write data
  output logic      [31:0] avs_readdata,         // read data
  output logic             avs_waitrequest       // high until request taken
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_END   = 4'b0100,
    ST_GAP   = 4'b1000
  } host_state_t;

  localparam logic [7:0] HALF_LAST = 8'(LINK_HALF_CYC - 1);

  typedef struct packed {
    host_state_t           st;
    logic [7:0]            ph;
    logic [4:0]            bitc;
    logic [FRAME_BITS-1:0] sh;
    logic [7:0]            rx;
    logic                  sclk;
    logic                  sel_n;
    logic                  mosi;
    logic [2:0]            ms;
    logic                  mf;
    logic                  wait_r;
    logic [31:0]           rdata;
  } host_state_s_t;

  host_state_s_t r_r;
  host_state_s_t r_nxt;

  always_comb begin
    logic busy;
    logic req;
    logic [FRAME_BITS-1:0] frame;
    r_nxt = r_r;
    busy = (r_r.st != ST_IDLE);
    req = avs_read | avs_write;
    frame = {avs_writedata[FRAME_WRITE_BIT], avs_writedata[14:8], avs_writedata[7:0]};
    r_nxt.ms = {r_r.ms[1:0], link.miso};
    r_nxt.mf = (r_r.ms[1] == r_r.ms[2]) ? r_r.ms[2] : r_r.mf;
    // a new command stalls until the running frame and the gap after it are over
    r_nxt.wait_r = !(req && r_r.wait_r && !(avs_write && avs_address == HOST_OFS_CMD && busy));
    if (req && r_r.wait_r && !r_nxt.wait_r) begin
      r_nxt.rdata = 32'h0000_0000;
      if (avs_address == HOST_OFS_STATUS) begin
        r_nxt.rdata[HOST_BUSY_BIT] = busy;
        r_nxt.rdata[HOST_DATA_LSB +: 8] = r_r.rx;
      end
    end
    unique case (r_r.st)
      ST_IDLE: begin
        if (!r_r.wait_r && avs_write && avs_address == HOST_OFS_CMD) begin
          r_nxt.st = ST_SHIFT;
          r_nxt.sh = frame;
          r_nxt.mosi = frame[FRAME_BITS-1];
          r_nxt.sel_n = 1'b0;
          r_nxt.ph = '0;
          r_nxt.bitc = '0;
        end
      end
      ST_SHIFT: begin
        r_nxt.ph = r_r.ph + 1'b1;
        if (r_r.ph == HALF_LAST) begin
          r_nxt.ph = '0;
          if (!r_r.sclk) begin
            r_nxt.sclk = 1'b1;
            if (r_r.bitc >= 5'(HDR_BITS)) r_nxt.rx = {r_r.rx[6:0], r_r.mf};
          end else begin
            r_nxt.sclk = 1'b0;
            r_nxt.bitc = r_r.bitc + 1'b1;
            r_nxt.sh = {r_r.sh[FRAME_BITS-2:0], 1'b0};
            r_nxt.mosi = r_r.sh[FRAME_BITS-2];
            if (r_r.bitc == 5'(FRAME_BITS - 1)) r_nxt.st = ST_END;
          end
        end
      end
      ST_END: begin
        r_nxt.ph = r_r.ph + 1'b1;
        if (r_r.ph == HALF_LAST) begin
          r_nxt.ph = '0;
          r_nxt.sel_n = 1'b1;
          r_nxt.st = ST_GAP;
        end
      end
      ST_GAP: begin
        // keeps select high long enough for the device filter to see it
        r_nxt.ph = r_r.ph + 1'b1;
        if (r_r.ph == HALF_LAST) begin
          r_nxt.ph = '0;
          r_nxt.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_r <= '0;
      r_r.st <= ST_IDLE;
      r_r.sel_n <= 1'b1;
      r_r.wait_r <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign link.sclk = r_r.sclk;
  assign link.sel_n = r_r.sel_n;
  assign link.mosi = r_r.mosi;
  assign avs_readdata = r_r.rdata;
  assign avs_waitrequest = r_r.wait_r;
endmodule // keypad_host

// >>> dv/keypad_link_props.sv
// protocol checker for the serial link between host controller and device
`timescale 1ns/100ps
module keypad_link_props
  import keypad_pkg::*;
(
  input wire logic core_clk_in, // 125 MHz clock
  input wire logic resetn_in,   // async reset, active low
  input wire logic sclk,        // link clock
  input wire logic sel_n,       // frame select, active low
  input wire logic mosi,        // host to device data
  input wire logic miso         // device to host data
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_lo10; !sclk[*8] ##1 !sclk ##1 !sclk; endsequence
  sequence s_hi10; sclk[*8] ##1 sclk ##1 sclk; endsequence
  sequence s_sel10; !sel_n[*8] ##1 !sel_n ##1 !sel_n; endsequence

  property p_idle_low; sel_n |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("link clock moved outside a frame");
  property p_hi_len; $rose(sclk) |-> s_hi10 ##1 !sclk; endproperty
  a_hi_len: assert property (p_hi_len)
    else $error("link clock high phase not ten cycles");
  property p_first_rise; $fell(sel_n) |-> s_lo10 ##1 sclk; endproperty
  a_first_rise: assert property (p_first_rise)
    else $error("first link clock rise misplaced");
  property p_lo_len; $fell(sclk) && !sel_n |-> s_lo10; endproperty
  a_lo_len: assert property (p_lo_len)
    else $error("link clock low phase too short");
  property p_sel_hold; $fell(sclk) |-> s_sel10; endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("select released too soon after a fall");
  property p_gap; $rose(sel_n) |-> sel_n[*8] ##1 sel_n ##1 sel_n; endproperty
  a_gap: assert property (p_gap)
    else $error("gap between frames too short");
  property p_mosi_stable; sclk && $past(sclk) |-> $stable(mosi); endproperty
  a_mosi_stable: assert property (p_mosi_stable)
    else $error("host data moved while link clock high");
  property p_rise_sel; $rose(sclk) |-> !sel_n; endproperty
  a_rise_sel: assert property (p_rise_sel)
    else $error("link clock rose without select");
  property p_frame_len; $fell(sel_n) |-> ##[330:350] $rose(sel_n); endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length out of range");
  c_miso: cover property (!sel_n && $rose(miso));
endmodule // keypad_link_props

// >>> dv/keypad_gpio_config_and_int_status_tb.sv
// self-checking bench: host controller and device joined over the serial link
`timescale 1ns/100ps
module keypad_gpio_config_and_int_status_tb;
  import keypad_pkg::*;
  localparam int DB = 20; // short debounce keeps the run brief
  localparam int SC = 64;
  logic             core_clk_in = 1'b0;
  logic             resetn_in = 1'b0;
  logic [PIN_N-1:0] pins_in, kp_sel_in, irq_en_in, data_out_in;
  logic [PIN_N-1:0] pin_drive_out, pin_oe_n_out, pullup_en_out, input_state_out;
  logic             pin_reset_n_in, key_event_in, lock_start_in, salute_in, overrun_event_in;
  logic             overrun_wrap_mode_in, overrun_irq_enable_in, soft_reset_out;
  logic [COL_N-1:0] key_accept_out;
  logic [ST_W-1:0]  status_out;
  logic             avs_address, avs_read, avs_write, avs_waitrequest;
  logic [31:0]      avs_writedata, avs_readdata;
  int               fail_count = 0;
  int               n_tests = 0;
  int               seed = 32'h183f6c4d;
  int               n;
  logic [7:0]       got, v, st;
  logic [7:0]       exp_q[$];
  logic [23:0]      cfg[4];
  event             rd_ev;
  logic [6:0] ofs[12] = '{OFS_DIR_ROWS, OFS_DIR_COLS_LO, OFS_DIR_COLS_HI, OFS_POL_ROWS, OFS_POL_COLS_LO,
    OFS_POL_COLS_HI, OFS_DBO_ROWS, OFS_DBO_COLS_LO, OFS_DBO_COLS_HI, OFS_PUO_ROWS, OFS_PUO_COLS_LO,
    OFS_PUO_COLS_HI};
  int         clr[4] = '{ST_SALUTE, ST_OVR, ST_LOCK, ST_KEY};

  keypad_link_if u_keypad_link_if ();
  keypad_dev #(.DEBOUNCE_CYCLES(DB), .SCAN_CYCLES(SC)) u_keypad_dev (.core_clk_in, .resetn_in,
    .link(u_keypad_link_if), .pins_in, .pin_reset_n_in, .kp_sel_in, .irq_en_in, .data_out_in, .key_event_in,
    .lock_start_in, .salute_in, .overrun_event_in, .overrun_wrap_mode_in, .overrun_irq_enable_in,
    .pin_drive_out, .pin_oe_n_out, .pullup_en_out, .input_state_out, .key_accept_out, .status_out,
    .soft_reset_out);
  keypad_host u_keypad_host (.core_clk_in, .resetn_in, .link(u_keypad_link_if), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  keypad_link_props u_keypad_link_props (.core_clk_in, .resetn_in, .sclk(u_keypad_link_if.sclk),
    .sel_n(u_keypad_link_if.sel_n), .mosi(u_keypad_link_if.mosi), .miso(u_keypad_link_if.miso));

  always #(CLK_PERIOD_NS / 2) core_clk_in = ~core_clk_in;

  task automatic chk(input logic [17:0] act, input logic [17:0] exp, input string m);
    n_tests++;
    if (act !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, act, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_in);
  endtask
  // request stands until the rising edge that samples waitrequest low; read data taken at that edge
  task automatic bus(input logic rd, input logic adr, input logic [31:0] wd, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge core_clk_in);
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_address   <= adr;
    avs_writedata <= wd;
    do @(posedge core_clk_in); while (avs_waitrequest !== 1'b0 && ++k < 2000);
    if (k >= 2000) chk(1'b1, 1'b0, "bus wait expired");
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic dev(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] b);
    logic [31:0] q;
    bus(1'b0, HOST_OFS_CMD, {16'h0000, w, a, d}, q);
    q = 32'h0000_0001;
    while (q[HOST_BUSY_BIT] !== 1'b0) bus(1'b1, HOST_OFS_STATUS, 32'h0000_0000, q);
    b = q[15:8];
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] b;
    dev(1'b1, a, d, b);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] b;
    dev(1'b0, a, 8'h00, b);
    exp_q.push_back(e);
    got = b;
    ->rd_ev;
  endtask

  always begin
    @(rd_ev);
    chk(got, exp_q.pop_front(), "register read");
  end

  initial begin
    repeat (90000) @(posedge core_clk_in);
    chk(1'b1, 1'b0, "watchdog expired");
    final_report();
  end

  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {kp_sel_in, irq_en_in, key_event_in, lock_start_in, salute_in, overrun_event_in} = '0;
    {overrun_wrap_mode_in, overrun_irq_enable_in} = '0;
    pins_in = 18'h3FFFF;
    pin_reset_n_in = 1'b1;
    data_out_in = 18'($random(seed));
    repeat (3) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 12; i++) rd(ofs[i], 8'h00);
    rd(OFS_INT_STATUS, 8'h00);
    chk(pin_oe_n_out, 18'h3FFFF, "oe reset");
    chk(pullup_en_out, 18'h3FFFF, "pullup reset");
    chk(input_state_out, RST_INPUT_STATE, "input state reset");
    $display("test reset_values done");
    for (int i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      wr(ofs[i], v);
      v = v & ((i % 3 == 2) ? 8'h03 : 8'hFF); // third register keeps two bits only
      cfg[i / 3][(i % 3) * 8 +: 8] = v;
      rd(ofs[i], v);
    end
    wr(7'h01, 8'hFF);
    rd(7'h01, 8'h00);
    chk(pin_oe_n_out, ~cfg[0][17:0], "direction to oe");
    chk(pullup_en_out, ~cfg[3][17:0], "pullup off");
    chk(pin_drive_out, data_out_in, "drive level");
    for (int i = 0; i < 12; i++) wr(ofs[i], 8'h00);
    $display("test config_regs done");
    @(posedge core_clk_in);
    {overrun_wrap_mode_in, overrun_event_in} <= 2'b11;
    @(posedge core_clk_in);
    overrun_event_in <= 1'b0;
    cyc(3);
    chk(status_out, 5'h00, "overrun needs enable");
    @(posedge core_clk_in);
    {overrun_irq_enable_in, overrun_event_in, key_event_in, lock_start_in, salute_in} <= 5'h1F;
    @(posedge core_clk_in);
    {overrun_event_in, key_event_in, lock_start_in, salute_in} <= 4'h0;
    cyc(3);
    // salute flag is only reported here, never taken as proof of the key combination
    chk(status_out, 5'h1D, "flags set");
    wr(OFS_INT_STATUS, 8'hE0);
    st = 8'h1D;
    rd(OFS_INT_STATUS, st);
    foreach (clr[i]) begin
      st[clr[i]] = 1'b0;
      wr(OFS_INT_STATUS, 8'h01 << clr[i]);
      rd(OFS_INT_STATUS, st);
    end
    $display("test status_flags done");
    wr(OFS_POL_ROWS, 8'h02);
    @(posedge core_clk_in);
    irq_en_in[1:0] <= 2'b11;
    pins_in[0] <= 1'b0;
    cyc(5);
    @(posedge core_clk_in);
    pins_in[0] <= 1'b1;
    pins_in[1] <= 1'b0;
    cyc(DB - 5);
    chk(input_state_out[1:0], 2'b11, "glitch and early change hidden");
    cyc(15);
    chk(input_state_out[1:0], 2'b01, "debounced change");
    chk(status_out, 5'h00, "falling ignored with rising polarity");
    @(posedge core_clk_in);
    pins_in[1] <= 1'b1;
    cyc(DB + 10);
    chk(status_out[ST_GPI], 1'b1, "rising triggers");
    wr(OFS_INT_STATUS, 8'h02);
    @(posedge core_clk_in);
    pins_in[0] <= 1'b0;
    cyc(DB + 10);
    chk(status_out[ST_GPI], 1'b1, "falling triggers");
    wr(OFS_INT_STATUS, 8'h02);
    rd(OFS_INT_STATUS, 8'h00);
    $display("test gpi_debounce done");
    wr(OFS_DBO_ROWS, 8'h0C);
    @(posedge core_clk_in);
    kp_sel_in[3] <= 1'b1;
    pins_in[3:2] <= 2'b00;
    cyc(8);
    chk(input_state_out[3:2], 2'b00, "debounce bypass");
    $display("test debounce_off done");
    @(posedge core_clk_in);
    kp_sel_in[COL_BASE] <= 1'b1;
    pins_in[COL_BASE] <= 1'b0;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (key_accept_out[0] !== 1'b1 && n < 400);
    chk(n >= SC && n <= 2 * SC + DB + 8, 1'b1, "key accept latency");
    chk(status_out[ST_KEY], 1'b1, "key flag on accept");
    $display("test key_scan done");
    wr(OFS_DIR_ROWS, 8'hA5);
    wr(OFS_DBO_ROWS, 8'hFF);
    @(posedge core_clk_in);
    pin_reset_n_in <= 1'b0;
    cyc(DB - 5);
    chk(soft_reset_out, 1'b0, "reset pin not yet taken");
    cyc(15);
    chk(soft_reset_out, 1'b1, "reset pin debounced");
    chk(pin_oe_n_out, 18'h3FFFF, "direction back to input");
    chk(status_out, 5'h00, "status cleared");
    @(posedge core_clk_in);
    pin_reset_n_in <= 1'b1;
    cyc(DB + 10);
    chk(soft_reset_out, 1'b0, "reset pin released");
    $display("test reset_pin done");
    final_report();
  end
endmodule // keypad_gpio_config_and_int_status_tb
